// ---- src/vbc_sub_band_calibration.sv ----
// Sub-band calibration controller: register file, measurement sequencer
// and modulator load. Assumes host writes arrive on the reference clock
// and that the VCO edge input is asynchronous.
`timescale 1ns/1ns
module vbc_sub_band_calibration
  import vbc_pkg::*;
#(
  parameter int CNT_W = 32 // Width of VCO and window counters
)
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Main serial port register access
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [23:0] reg_wdata,
  output logic [23:0]      reg_rdata,
  output logic             reg_rvalid,
  // VCO edge from the oscillator divider
  input  wire logic        vco_edge,
  // Modulator and sub-band outputs
  output logic [23:0]      mod_frac,
  output logic             cal_busy,
  // Internal VCO serial link pins
  output logic             vlink_sck,
  output logic             vlink_sdo,
  output logic             vlink_sen_n
);
  import vbc_pkg::*;

  // Narrower counters could not hold the longest window; refused at elaboration
  if (CNT_W < 32 || CNT_W > 48)
  begin : g_bad_cnt_w
    $error("CNT_W must lie between 32 and 48");
  end

  vbc_link_if lnk ();

  // ==========================================================
  // Register file
  logic [23:0] ref_div_reg, int_div_reg, frac_div_reg, link_reg, cfg_reg;
  logic [VBC_SW_BITS-1:0] result_reg;

  wire wr_frac = reg_wr && (reg_addr == VBC_OFS_FRAC_DIV);
  wire cal_en  = !cfg_reg[VBC_CALDIS_BIT];
  wire start   = wr_frac && cal_en && !cal_busy;

  // Host writes; divider values are not sampled at start, so a write during a run takes effect at once
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ref_div_reg  <= VBC_RST_REF_DIV;
      int_div_reg  <= VBC_RST_INT_DIV;
      frac_div_reg <= VBC_RST_FRAC_DIV;
      link_reg     <= VBC_RST_LINK;
      cfg_reg      <= VBC_RST_CAL_CFG;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        VBC_OFS_REF_DIV:   ref_div_reg  <= reg_wdata;
        VBC_OFS_INT_DIV:   int_div_reg  <= reg_wdata;
        VBC_OFS_FRAC_DIV:  frac_div_reg <= reg_wdata;
        VBC_OFS_LINK_WORD: link_reg     <= reg_wdata;
        VBC_OFS_CAL_CFG:   cfg_reg      <= reg_wdata;
        default:           ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  logic [23:0] rd_mux;
  always_comb
  begin
    case (reg_addr)
      VBC_OFS_REF_DIV:   rd_mux = ref_div_reg;
      VBC_OFS_INT_DIV:   rd_mux = int_div_reg;
      VBC_OFS_FRAC_DIV:  rd_mux = frac_div_reg;
      VBC_OFS_LINK_WORD: rd_mux = link_reg;
      VBC_OFS_CAL_CFG:   rd_mux = cfg_reg;
      VBC_OFS_STATUS:    rd_mux = {15'h0000, cal_busy, 3'h0, result_reg};
      default:           rd_mux = 24'h00_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      reg_rdata  <= 24'h00_0000;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end

  // ==========================================================
  // Calibration clock strobe
  logic [5:0] presc_reg;
  logic [5:0] div_max;
  wire  [1:0] cdiv = cfg_reg[VBC_CDIV_LSB +: 2];
  always_comb
  begin
    case (cdiv)
      2'b00:   div_max = 6'h00;
      2'b01:   div_max = 6'h03;
      2'b10:   div_max = 6'h0F;
      default: div_max = 6'h1F;
    endcase
  end
  wire fsm_tick = (presc_reg >= div_max);

  always_ff @(posedge clock)
  begin
    if (!rst_n)
      presc_reg <= 6'h00;
    else
      presc_reg <= fsm_tick ? 6'h00 : presc_reg + 6'h01;
  end

  // ==========================================================
  // Measurement arithmetic
  wire [2:0] mlen = cfg_reg[VBC_MLEN_LSB +: 3];
  wire [3:0] n_exp = mlen[2] ? {1'b0, mlen} + 4'h1 : {1'b0, mlen};
  // Ratio with 24 fraction bits, scaled by 2^n, floor by dropping fraction
  wire [55:0] ratio_fx  = {8'h00, int_div_reg, frac_div_reg};
  wire [55:0] ratio_shl = ratio_fx << n_exp;
  wire [CNT_W-1:0] expected = CNT_W'(ratio_shl[55:VBC_FRAC_BITS]);
  wire [CNT_W-1:0] win_len  = CNT_W'({8'h00, ref_div_reg} << n_exp);
  wire [9:0]  wait_len = 10'(cfg_reg[VBC_WAIT_LSB +: 2] * VBC_WAIT_UNIT);

  // VCO edge crosses in through two flops; the rise is found by comparing the second with a third
  logic vco_s1_reg, vco_s2_reg, vco_s3_reg;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      vco_s1_reg <= 1'b0;
      vco_s2_reg <= 1'b0;
      vco_s3_reg <= 1'b0;
    end
    else
    begin
      vco_s1_reg <= vco_edge;
      vco_s2_reg <= vco_s1_reg;
      vco_s3_reg <= vco_s2_reg;
    end
  end
  wire vco_rise = vco_s2_reg && !vco_s3_reg;

  // ==========================================================
  // Sequencer
  vbc_state_t state_reg, state_next;
  logic [2:0]             step_reg;
  logic [VBC_SW_BITS-1:0] trial_reg;
  logic [9:0]             wait_reg;
  logic [CNT_W-1:0]       win_reg, cnt_reg;

  wire last_bit  = (step_reg == 3'(VBC_MEAS_STEPS - 1));
  wire wait_done = fsm_tick && (wait_reg >= wait_len);
  wire win_done  = (win_reg >= win_len - CNT_W'(1));
  wire too_fast  = (cnt_reg > expected);
  // Trial for the next step: set next lower bit; last step rechecks result
  wire [VBC_SW_BITS-1:0] kept = too_fast ? trial_reg : result_reg;
  wire [VBC_SW_BITS-1:0] bit_mask = VBC_SW_BITS'(1) << (3'(VBC_SW_BITS - 2) - step_reg);
  // First trial is the msb alone; the stale trial of a past run must not go out
  wire [VBC_SW_BITS-1:0] first_trial = VBC_SW_BITS'(1) << (VBC_SW_BITS - 1);
  // Final recheck nudges one band up when still fast
  wire [VBC_SW_BITS-1:0] nudged = (too_fast && (&result_reg == 1'b0)) ?
                                  result_reg + VBC_SW_BITS'(1) : result_reg;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      VBC_IDLE:  if (start) state_next = VBC_XFER;
      VBC_XFER:  if (lnk.done) state_next = VBC_WAIT;
      VBC_WAIT:  if (wait_done) state_next = VBC_MEAS;
      VBC_MEAS:  if (win_done) state_next = last_bit ? VBC_FINAL : VBC_XFER;
      VBC_FINAL: if (lnk.done) state_next = VBC_LOAD;
      VBC_LOAD:  state_next = VBC_IDLE;
      default:   state_next = VBC_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg  <= VBC_IDLE;
      step_reg   <= 3'h0;
      trial_reg  <= '0;
      result_reg <= '0;
      wait_reg   <= 10'h000;
      win_reg    <= '0;
      cnt_reg    <= '0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg  <= (state_reg != VBC_WAIT) ? 10'h000 :
                   fsm_tick ? wait_reg + 10'h001 : wait_reg;
      if (state_reg == VBC_MEAS)
      begin
        win_reg <= win_reg + CNT_W'(1);
        cnt_reg <= cnt_reg + CNT_W'(vco_rise);
      end
      else
      begin
        win_reg <= '0;
        cnt_reg <= '0;
      end
      if (start)
      begin
        step_reg   <= 3'h0;
        result_reg <= '0;
        trial_reg  <= first_trial;
      end
      else if (state_reg == VBC_MEAS && win_done)
      begin
        step_reg <= step_reg + 3'h1;
        if (last_bit)
          result_reg <= nudged;
        else
        begin
          result_reg <= kept;
          trial_reg  <= (step_reg == 3'(VBC_SW_BITS - 1)) ? kept : (kept | bit_mask);
        end
      end
    end
  end

  assign cal_busy = (state_reg != VBC_IDLE);

  // ==========================================================
  // Modulator load: deferred while calibrating, immediate when disabled
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      mod_frac <= VBC_RST_FRAC_DIV;
    else if (state_reg == VBC_LOAD)
      mod_frac <= frac_div_reg;
    else if (wr_frac && !cal_en && !cal_busy)
      mod_frac <= reg_wdata;
  end

  // ==========================================================
  // Link drive: host words pass straight through when idle, so a mute
  // sequence never stalls the loop or a later calibration
  wire host_send = reg_wr && (reg_addr == VBC_OFS_LINK_WORD) && !cal_busy && !lnk.busy;
  wire cal_send = ((state_reg == VBC_IDLE) && start) ||
                  ((state_reg == VBC_MEAS) && win_done);
  // Slight hazard: the final word uses the updated result, so it is sent next cycle
  logic final_pend_reg;
  always_ff @(posedge clock)
  begin
    if (!rst_n)
      final_pend_reg <= 1'b0;
    else
      final_pend_reg <= (state_reg == VBC_MEAS) && win_done && last_bit;
  end

  assign lnk.tick  = fsm_tick;
  assign lnk.start = host_send || (cal_send && !last_bit) || (cal_send && state_reg == VBC_IDLE) ||
                     final_pend_reg;
  assign lnk.word  = host_send ? reg_wdata[15:0] :
                     final_pend_reg ? {4'h0, result_reg, VBC_CAL_VREG, link_reg[2:0]} :
                     (state_reg == VBC_IDLE) ? {4'h0, first_trial, VBC_CAL_VREG, link_reg[2:0]} :
                     {4'h0, kept | bit_mask, VBC_CAL_VREG, link_reg[2:0]};

  vbc_serial_link u_link (
    .clock (clock),
    .rst_n (rst_n),
    .lnk   (lnk.link),
    .sck   (vlink_sck),
    .sdo   (vlink_sdo),
    .sen_n (vlink_sen_n)
  );

  // ==========================================================
  // Checks
  logic [5:0] xfer_ticks_reg;
  always_ff @(posedge clock)
  begin
    if (!rst_n || lnk.start)
      xfer_ticks_reg <= 6'h00;
    else if (lnk.busy && fsm_tick)
      xfer_ticks_reg <= xfer_ticks_reg + 6'h01;
  end

  property p_link_len;
    @(posedge clock) disable iff (!rst_n) lnk.done |-> xfer_ticks_reg == 6'd20;
  endproperty
  a_link_len: assert property (p_link_len) else $error("link transfer not 20 ticks");

  property p_wait_len;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == VBC_WAIT && state_next == VBC_MEAS) |-> wait_reg == wait_len;
  endproperty
  a_wait_len: assert property (p_wait_len) else $error("wait length wrong");

  property p_win_len;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == VBC_MEAS && state_next != VBC_MEAS) |-> win_reg + CNT_W'(1) == win_len;
  endproperty
  a_win_len: assert property (p_win_len) else $error("measurement window wrong");

  property p_frac_hold;
    @(posedge clock) disable iff (!rst_n)
      (cal_busy && state_reg != VBC_LOAD) |=> $stable(mod_frac);
  endproperty
  a_frac_hold: assert property (p_frac_hold) else $error("modulator changed mid run");

  property p_frac_load;
    @(posedge clock) disable iff (!rst_n)
      (state_reg == VBC_FINAL && lnk.done) |=> ##1 mod_frac == frac_div_reg;
  endproperty
  a_frac_load: assert property (p_frac_load) else $error("fraction not loaded");

  property p_start;
    @(posedge clock) disable iff (!rst_n)
      (wr_frac && cal_en && !cal_busy) |=> state_reg == VBC_XFER && lnk.busy;
  endproperty
  a_start: assert property (p_start) else $error("calibration did not start");

  property p_direct;
    @(posedge clock) disable iff (!rst_n)
      (wr_frac && !cal_en && !cal_busy) |=> mod_frac == $past(reg_wdata);
  endproperty
  a_direct: assert property (p_direct) else $error("direct load missing");

  property p_tick;
    // A divider rewrite inside the spacing window legally moves the next tick
    @(posedge clock) disable iff (!rst_n || (reg_wr && reg_addr == VBC_OFS_CAL_CFG))
      (fsm_tick && cdiv == 2'b01 && $stable(cdiv)) |=> !fsm_tick [*3] ##1 fsm_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("divide by 4 tick spacing wrong");

  property p_steps;
    @(posedge clock) disable iff (!rst_n) (state_reg == VBC_LOAD) |-> step_reg == 3'd6;
  endproperty
  a_steps: assert property (p_steps) else $error("measurement count wrong");

  c_full_run: cover property (@(posedge clock) disable iff (!rst_n) state_reg == VBC_LOAD);
  c_waits:    cover property (@(posedge clock) disable iff (!rst_n) state_reg == VBC_WAIT && wait_len != 10'h000);
  c_host_tx:  cover property (@(posedge clock) disable iff (!rst_n) host_send);

endmodule : vbc_sub_band_calibration

// ---- src/vbc_pkg.sv ----
// Shared constants for the sub-band calibration controller.
// Assumes a single reference clock domain; all counts are in reference
// or calibration-clock cycles as noted.
package vbc_pkg;

  // ==========================================================
  // Register offsets (word indices on the main serial port)
  localparam logic [4:0] VBC_OFS_REF_DIV   = 5'h02;
  localparam logic [4:0] VBC_OFS_INT_DIV   = 5'h03;
  localparam logic [4:0] VBC_OFS_FRAC_DIV  = 5'h04;
  localparam logic [4:0] VBC_OFS_LINK_WORD = 5'h05;
  localparam logic [4:0] VBC_OFS_CAL_CFG   = 5'h0A;
  localparam logic [4:0] VBC_OFS_STATUS    = 5'h10;

  // ==========================================================
  // Field positions in the calibration configuration and status registers
  localparam int VBC_MLEN_LSB   = 0;  // Measurement length, 3 bits
  localparam int VBC_WAIT_LSB   = 6;  // Wait-state multiplier k, 2 bits
  localparam int VBC_CALDIS_BIT = 11; // Calibration disable
  localparam int VBC_CDIV_LSB   = 13; // Calibration clock divider, 2 bits
  localparam int VBC_BUSY_BIT   = 8;  // Status: calibration running

  // ==========================================================
  // Reset values
  localparam logic [23:0] VBC_RST_REF_DIV  = 24'h00_0001;
  localparam logic [23:0] VBC_RST_INT_DIV  = 24'h00_0019;
  localparam logic [23:0] VBC_RST_FRAC_DIV = 24'h00_0000;
  localparam logic [23:0] VBC_RST_LINK     = 24'h00_0000;
  localparam logic [23:0] VBC_RST_CAL_CFG  = 24'h00_0000;

  // ==========================================================
  // Timing and sizing
  localparam int          VBC_FRAC_BITS   = 24;  // Fraction scale 2^24
  localparam int          VBC_SW_BITS     = 5;   // Sub-band switch width
  localparam int          VBC_MEAS_STEPS  = 6;   // Measurements per run
  localparam logic [9:0]  VBC_WAIT_UNIT   = 10'h064; // 100 FSM cycles per k
  localparam int          VBC_LINK_CYCLES = 20;  // FSM cycles per transfer
  localparam int          VBC_LINK_BITS   = 16;  // Serial word length
  localparam logic [3:0]  VBC_CAL_VREG    = 4'h0;    // Sub-band switch register

  // ==========================================================
  // Calibration sequencer states
  typedef enum logic [2:0] {
    VBC_IDLE  = 3'b000,
    VBC_XFER  = 3'b001,
    VBC_WAIT  = 3'b010,
    VBC_MEAS  = 3'b011,
    VBC_FINAL = 3'b100,
    VBC_LOAD  = 3'b101
  } vbc_state_t;

endpackage : vbc_pkg

// ---- src/vbc_link_if.sv ----
// Carrier between the calibration sequencer and its serial link.
// Assumes both ends share the reference clock; tick is the divided
// calibration clock strobe.
`timescale 1ns/1ns
interface vbc_link_if;
  logic        tick;  // One reference cycle per calibration clock period
  logic        start; // Load word and begin a transfer
  logic [15:0] word;  // Word to shift out, msb first
  logic        busy;  // Transfer in progress
  logic        done;  // One-cycle pulse at end of transfer

  modport ctrl (output tick, output start, output word, input busy, input done);
  modport link (input tick, input start, input word, output busy, output done);
endinterface : vbc_link_if

// ---- src/vbc_serial_link.sv ----
// Internal VCO subsystem serial link shifter.
// Assumes start is only raised while busy is low.
`timescale 1ns/1ns
module vbc_serial_link
  import vbc_pkg::*;
(
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Sequencer side
  vbc_link_if.link  lnk,
  // Serial pins
  output logic      sck,
  output logic      sdo,
  output logic      sen_n
);
  import vbc_pkg::*;

  localparam logic [4:0] LAST_CYC = 5'(VBC_LINK_CYCLES - 1);
  localparam logic [4:0] NBITS    = 5'(VBC_LINK_BITS);

  logic [4:0]  cyc_reg;
  logic [15:0] shf_reg;
  logic        busy_reg;
  logic        done_reg;

  // ==========================================================
  // Transfer timing
  // Data bits occupy the first 16 ticks, then idle ticks fill out 20
  wire in_data = busy_reg && (cyc_reg < NBITS);
  wire at_end  = busy_reg && lnk.tick && (cyc_reg == LAST_CYC);

  // Counter and shifter advance on the calibration tick; pins are registered every reference cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cyc_reg  <= 5'h00;
      shf_reg  <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      sck      <= 1'b0;
      sdo      <= 1'b0;
      sen_n    <= 1'b1;
    end
    else
    begin
      done_reg <= at_end;
      sck      <= in_data && lnk.tick;
      sen_n    <= !in_data;
      sdo      <= in_data ? shf_reg[15] : 1'b0;
      if (lnk.start && !busy_reg)
      begin
        busy_reg <= 1'b1;
        cyc_reg  <= 5'h00;
        shf_reg  <= lnk.word;
      end
      else if (busy_reg && lnk.tick)
      begin
        cyc_reg  <= at_end ? 5'h00 : cyc_reg + 5'h01;
        busy_reg <= !at_end;
        if (in_data)
          shf_reg <= {shf_reg[14:0], 1'b0};
      end
    end
  end

  assign lnk.busy = busy_reg;
  assign lnk.done = done_reg;

endmodule : vbc_serial_link

// ---- testbench/vbc_vco_model.sv ----
// Behavioural VCO subsystem: serial register file and switch-tuned oscillator.
// Assumes link pins change on the reference clock; the oscillator runs free.
`timescale 1ns/1ns
module vbc_vco_model
(
  // Clock and reset
  input  wire logic   clock,
  input  wire logic   rst_n,
  // Serial link pins
  input  wire logic   sck,
  input  wire logic   sdo,
  input  wire logic   sen_n,
  // Oscillator and observation
  output logic        vco_edge,
  output logic        rf_on,
  output logic [15:0] last_word,
  output int          frames,
  output int          bits,
  output int          gap,
  output int          edges
);
  logic [8:0]  regs [0:15];
  logic [15:0] shift_reg;
  logic        sen_q;
  int          since;

  initial regs = '{default: 9'h000};
  initial vco_edge = 1'b0;

  // ==========================================================
  // Link receiver: shift on strobe, commit when enable returns high
  always @(posedge clock)
  begin
    since <= since + 1;
    sen_q <= sen_n;
    if (!rst_n)
    begin
      frames <= 0;
      bits   <= 0;
    end
    else if (!sen_n && sck)
    begin
      shift_reg <= {shift_reg[14:0], sdo};
      bits      <= bits + 1;
      gap       <= since;
      since     <= 1;
    end
    else if (sen_n && !sen_q)
    begin
      last_word             <= shift_reg;
      frames                <= frames + 1;
      regs[shift_reg[6:3]]  <= shift_reg[15:7];
    end
  end

  // ==========================================================
  // More capacitance, slower oscillator; mute never stops it
  always
  begin
    #(11 + int'(regs[0][4:0])) vco_edge = ~vco_edge;
  end

  always @(posedge vco_edge) edges <= edges + 1;

  // Output stays on unless manual mode, buffer off and limiter off
  assign rf_on = !(regs[3][2] && regs[1][2] && !regs[1][3]);
endmodule : vbc_vco_model

// ---- testbench/testbench.sv ----
// Self-checking bench for the sub-band calibration controller.
// Assumes the VCO model on the far side of the link pins.
`timescale 1ns/1ns
module testbench;
  import vbc_pkg::*;
  logic        clock, rst_n, reg_wr, reg_rd, reg_rvalid, vco_edge, cal_busy;
  logic        vlink_sck, vlink_sdo, vlink_sen_n, rf_on;
  logic [4:0]  reg_addr;
  logic [23:0] reg_wdata, reg_rdata, mod_frac;
  logic [15:0] last_word;
  int          frames, bits, gap, edges, miscompares, compares;

  vbc_sub_band_calibration u_dut (.clock(clock), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .vco_edge(vco_edge), .mod_frac(mod_frac), .cal_busy(cal_busy), .vlink_sck(vlink_sck),
    .vlink_sdo(vlink_sdo), .vlink_sen_n(vlink_sen_n));
  vbc_vco_model u_vco (.clock(clock), .rst_n(rst_n), .sck(vlink_sck), .sdo(vlink_sdo),
    .sen_n(vlink_sen_n), .vco_edge(vco_edge), .rf_on(rf_on), .last_word(last_word),
    .frames(frames), .bits(bits), .gap(gap), .edges(edges));

  // ==========================================================
  // Clock, comparisons and verdict
  initial clock = 1'b0;
  always #5 clock = ~clock;

  task automatic close_out;
    if (miscompares == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  task automatic check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask : check

  // ==========================================================
  // Register port cycles, driven on the falling edge
  task automatic wr(input logic [4:0] a, input logic [23:0] d);
    @(negedge clock);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr    = 1'b0;
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [23:0] d);
    @(negedge clock);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd   = 1'b0;
    check(reg_rvalid === 1'b1, "read answer missing");
    d = reg_rdata;
  endtask : rd

  // Divider code 0 would clock the sequencer at 100 MHz, so it is never used
  task automatic set_cfg(input int cdiv, input int k, input int c, input logic dis);
    wr(VBC_OFS_CAL_CFG, (24'(cdiv) << VBC_CDIV_LSB) | (24'(k) << VBC_WAIT_LSB)
       | (24'(dis) << VBC_CALDIS_BIT) | 24'(c));
  endtask : set_cfg

  // Start a run by a fraction write and count cycles until idle
  task automatic run_cal(input logic [23:0] f, output int cyc);
    logic [23:0] old;
    int          f0;
    old = mod_frac;
    f0  = frames;
    cyc = 0;
    wr(VBC_OFS_FRAC_DIV, f);
    while (cal_busy !== 1'b0 || cyc == 0)
    begin
      @(negedge clock);
      cyc++;
      if (mod_frac !== old) check(frames == f0 + 7, "fraction loaded before final switch");
      old = mod_frac;
      if (cyc > 30000)
      begin
        check(1'b0, "calibration never ended");
        close_out();
      end
    end
    check(cyc > 1, "fraction write did not start a run");
  endtask : run_cal

  task automatic send_link(input logic [15:0] w);
    int f0;
    int b0;
    f0 = frames;
    b0 = bits;
    wr(VBC_OFS_LINK_WORD, {8'h00, w});
    for (int i = 0; i < 3000 && frames == f0; i++) @(negedge clock);
    check(frames == f0 + 1 && bits == b0 + 16, "link frame length");
    check(last_word === w, "link word on wire");
    if (frames == f0)
      close_out();
    // Link stays busy for its idle tail after the frame; let it drain
    repeat (4 * 32) @(negedge clock);
  endtask : send_link

  // Successive approximation over the model's period law, then nudge
  function automatic logic [4:0] exp_switch(input int v, input int win);
    logic [4:0] s;
    s = 5'h00;
    for (int b = 4; b >= 0; b--)
    begin
      if (win > v * (22 + 2 * (s | (5'h01 << b))))
        s = s | (5'h01 << b);
    end
    if (s != 5'h1F && win > v * (22 + 2 * s))
      s = s + 5'h01;
    return s;
  endfunction : exp_switch

  // ==========================================================
  // Scenarios
  task automatic t_reset_regs;
    logic [23:0] d;
    rd(VBC_OFS_REF_DIV, d);
    check(d === VBC_RST_REF_DIV, "reference divider reset value");
    rd(VBC_OFS_INT_DIV, d);
    check(d === VBC_RST_INT_DIV, "integer divider reset value");
    rd(VBC_OFS_CAL_CFG, d);
    check(d === VBC_RST_CAL_CFG, "calibration config reset value");
    wr(5'h1F, 24'hFF_FFFF);
    rd(5'h1F, d);
    check(d === 24'h00_0000, "unmapped offset read");
    wr(VBC_OFS_STATUS, 24'h00_00FF);
    rd(VBC_OFS_STATUS, d);
    check(d === 24'h00_0000, "status must be read-only");
    wr(VBC_OFS_REF_DIV, 24'h12_3456);
    rd(VBC_OFS_REF_DIV, d);
    check(d === 24'h12_3456, "reference divider write");
  endtask : t_reset_regs

  task automatic t_disabled;
    set_cfg(1, 0, 0, 1'b1);
    wr(VBC_OFS_FRAC_DIV, 24'h5A_5A5A);
    @(negedge clock);
    check(mod_frac === 24'h5A_5A5A && cal_busy === 1'b0, "direct fraction load");
  endtask : t_disabled

  task automatic t_mute;
    int e0;
    set_cfg(1, 0, 0, 1'b0);
    send_link(16'h0218);
    send_link(16'h0608);
    send_link(16'h0208);
    check(rf_on === 1'b0, "output not muted");
    e0 = edges;
    repeat (20) @(negedge clock);
    check(edges > e0 + 3, "oscillator stopped by mute");
  endtask : t_mute

  task automatic t_search(input logic [23:0] i, input logic [23:0] f);
    int          cyc;
    int          f0;
    logic [4:0]  sw;
    logic [23:0] d;
    sw = exp_switch(int'(i) * 8 + int'(f >> 21), 64 * 8 * 10);
    wr(VBC_OFS_REF_DIV, 24'h00_0040);
    wr(VBC_OFS_INT_DIV, i);
    set_cfg(1, 0, 3, 1'b0);
    f0 = frames;
    run_cal(f, cyc);
    check(frames == f0 + 7, "link transfers per run");
    check(last_word === {4'h0, sw, 4'h0, 3'b000}, "final switch word");
    rd(VBC_OFS_STATUS, d);
    check(d === {16'h0000, 3'b000, sw}, "status switch value");
    check(mod_frac === f, "fraction not loaded after run");
  endtask : t_search

  task automatic t_lengths;
    int cyc;
    int n;
    int lo;
    wr(VBC_OFS_REF_DIV, 24'h00_0001);
    for (int c = 0; c < 8; c++)
    begin
      n = (c < 4) ? c : c + 1;
      set_cfg(1, 0, c, 1'b0);
      run_cal(24'h00_0000, cyc);
      lo = 6 * (1 << n) + 140 * 4;
      check(cyc >= lo, "window length for code");
      check(cyc <= lo + 104, "worst-case duration exceeded");
    end
  endtask : t_lengths

  task automatic t_clkdiv;
    int cyc;
    int m;
    int k;
    for (int i = 1; i < 4; i++)
    begin
      m = (i == 3) ? 5 : 2 * i;
      k = (4 - i) % 3;
      set_cfg(i, k, 0, 1'b0);
      run_cal(24'h00_0000, cyc);
      check(gap == (1 << m), "link strobe spacing");
      check(cyc >= 6 + (140 + 100 * k) * (1 << m), "transfers and waits too short");
      if (k == 0) check(cyc <= 6 + 164 * (1 << m) + 8, "worst-case duration exceeded");
    end
  endtask : t_clkdiv

  // ==========================================================
  // Main sequence
  initial
  begin
    rst_n       = 1'b0;
    reg_wr      = 1'b0;
    reg_rd      = 1'b0;
    reg_addr    = 5'h00;
    reg_wdata   = 24'h00_0000;
    miscompares = 0;
    compares    = 0;
    repeat (4) @(posedge clock);
    @(negedge clock);
    rst_n = 1'b1;
    t_reset_regs();
    t_disabled();
    t_mute();
    t_search(24'h00_0019, 24'h00_0000);
    t_search(24'h00_0017, 24'hC0_0000);
    t_lengths();
    t_clkdiv();
    close_out();
  end
endmodule : testbench
